// [design/acr_amp_ctrl.sv]
// Purpose: register bank and power sequencing of a mono digital-input amplifier
// Assumes: SCL and SDA are synchronous to CORE_CLK and slow against it
// Notes: SDA is open drain, driven low only; RST is the supply power-on reset
//
// What this block does
// - shutdown when power control bit 0 is 0 or the shutdown pin is low.
// - serial register access keeps working in shutdown; registers keep their contents.
// - shutdown control bit resets to 1; 0 requests shutdown, 1 releases.
// - sleep bit set ramps volume down, then output stage goes high impedance.
// - sleep keeps other blocks ready; sleep bit resets to 0.
// - power control bits 7..2 hold clip level bits 19..14.
// - clipper limits every sample magnitude to the programmed clip level.
// - offset 0 is read-only and always returns the fixed part code.
// - every register loads its default value at power-on reset.
// - latched fault flags clear only on shutdown toggle; sleep leaves them.
`timescale 1ns/1ns
module acr_amp_ctrl #(
  parameter logic [6:0] DEV_ADDR = 7'h2c,
  parameter logic [7:0] PART_IDENT_CODE = 8'h5a, // arbitrary value
  parameter int RAMP_CYCLES = acr_pkg::RAMP_STEP_CYCLES
) (
  // clock and power-on reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // serial control port
  input wire logic SCL,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE,
  // pins and fault sources
  input wire logic SHUTDOWN_N_PIN,
  input wire logic CLOCK_ERR_IN,
  input wire acr_pkg::acr_faults_t FAULT_EVT,
  // audio path
  input wire logic signed [acr_pkg::CLIP_W:0] SAMPLE_IN,
  input wire logic SAMPLE_VALID,
  output logic signed [acr_pkg::CLIP_W:0] DAC_SAMPLE,
  output logic DAC_VALID,
  // power state and configuration
  output logic SHUTDOWN_ACTIVE,
  output logic STAGE_ENABLE,
  output logic [7:0] VOLUME_LEVEL,
  output logic FAULT_N,
  output acr_pkg::acr_cfg_t CFG
);
  // ==========================================================
  // registers
  logic [7:0] power_ctrl_q, dig_ctrl1_q, dig_ctrl2_q, volume_q, analog_q;
  logic [7:0] fault_cfg_q, clip_mid_q, clip_low_q;
  acr_pkg::acr_faults_t faults_q;
  logic shutdown_q, stage_q, fault_n_q, dac_valid_q;
  logic [7:0] vol_level_q;
  logic [15:0] ramp_cnt_q;
  logic signed [acr_pkg::CLIP_W:0] dac_q;
  // serial port state
  acr_pkg::acr_state_t state_q, next_after_ack_q;
  logic scl_q, scl_prev_q, sda_q, sda_prev_q, sda_oe_q;
  logic [3:0] cnt_q;
  logic [7:0] shift_q, tx_q, ptr_q;

  // ==========================================================
  // register read decode
  function automatic logic [7:0] read_reg(input logic [7:0] a, input logic [7:0] fault_rd);
    case (a)
      acr_pkg::OFS_PART_IDENT: read_reg = PART_IDENT_CODE;
      acr_pkg::OFS_POWER_CTRL: read_reg = power_ctrl_q;
      acr_pkg::OFS_DIG_CTRL1: read_reg = dig_ctrl1_q;
      acr_pkg::OFS_DIG_CTRL2: read_reg = dig_ctrl2_q;
      acr_pkg::OFS_VOLUME: read_reg = volume_q;
      acr_pkg::OFS_ANALOG: read_reg = analog_q;
      acr_pkg::OFS_FAULT: read_reg = fault_rd;
      acr_pkg::OFS_CLIP_MID: read_reg = clip_mid_q;
      acr_pkg::OFS_CLIP_LOW: read_reg = clip_low_q;
      default: read_reg = 8'h00;
    endcase
  endfunction

  // ==========================================================
  // serial port decode
  wire scl_rise = scl_q & ~scl_prev_q;
  wire scl_fall = ~scl_q & scl_prev_q;
  wire start_seen = scl_q & scl_prev_q & sda_prev_q & ~sda_q;
  wire stop_seen = scl_q & scl_prev_q & ~sda_prev_q & sda_q;
  wire byte_done = scl_fall & (cnt_q == 4'd8);
  wire addr_hit = (shift_q[7:1] == DEV_ADDR);
  wire wr_fire = byte_done & (state_q == acr_pkg::S_WR);
  // the clock error bit reads as set in shutdown: the error detector is powered down then
  wire clk_err_rd = shutdown_q | CLOCK_ERR_IN;
  wire [7:0] fault_rd = {fault_cfg_q[7:4], clk_err_rd, faults_q.overcurrent,
                         faults_q.dc_offset, faults_q.overheat};
  logic [7:0] rd_data;
  // a process, so a register write under an unchanged pointer still reaches the read path
  always_comb begin
    rd_data = read_reg(ptr_q, fault_rd);
  end

  // ==========================================================
  // power state
  wire shutdown_d = ~power_ctrl_q[acr_pkg::BIT_SHUTDOWN_N] | ~SHUTDOWN_N_PIN;
  wire shutdown_enter = shutdown_d & ~shutdown_q;
  wire fault_any = faults_q.overheat | faults_q.overcurrent | faults_q.dc_offset;
  // faults and clock errors force sleep without touching the sleep bit
  wire sleep_eff = power_ctrl_q[acr_pkg::BIT_SLEEP] | fault_any | CLOCK_ERR_IN;
  wire stage_off_req = shutdown_d | sleep_eff;
  wire play = ~stage_off_req & ~dig_ctrl2_q[acr_pkg::BIT_MUTE];
  wire [7:0] vol_target = play ? volume_q : 8'h00;
  wire ramp_tick = (ramp_cnt_q == 16'(RAMP_CYCLES - 1));
  wire [acr_pkg::CLIP_W-1:0] clip_level = {power_ctrl_q[7:2], clip_mid_q, clip_low_q[7:2]};
  wire signed [acr_pkg::CLIP_W:0] clip_pos = $signed({1'b0, clip_level});
  wire signed [acr_pkg::CLIP_W:0] clip_neg = -clip_pos;

  // ==========================================================
  // register file; shutdown never gates writes
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      power_ctrl_q <= acr_pkg::RST_POWER_CTRL;
      dig_ctrl1_q <= acr_pkg::RST_DIG_CTRL1;
      dig_ctrl2_q <= acr_pkg::RST_DIG_CTRL2;
      volume_q <= acr_pkg::RST_VOLUME;
      analog_q <= acr_pkg::RST_ANALOG;
      fault_cfg_q <= acr_pkg::RST_FAULT_CFG;
      clip_mid_q <= acr_pkg::RST_CLIP_MID;
      clip_low_q <= acr_pkg::RST_CLIP_LOW;
    end else if (wr_fire) begin
      case (ptr_q)
        acr_pkg::OFS_POWER_CTRL: power_ctrl_q <= shift_q;
        acr_pkg::OFS_DIG_CTRL1: dig_ctrl1_q <= shift_q;
        acr_pkg::OFS_DIG_CTRL2: dig_ctrl2_q <= shift_q;
        acr_pkg::OFS_VOLUME: volume_q <= shift_q;
        acr_pkg::OFS_ANALOG: analog_q <= shift_q;
        acr_pkg::OFS_FAULT: fault_cfg_q <= {shift_q[7:4], 4'h0};
        acr_pkg::OFS_CLIP_MID: clip_mid_q <= shift_q;
        acr_pkg::OFS_CLIP_LOW: clip_low_q <= shift_q;
        default: ;
      endcase
    end
  end

  // ==========================================================
  // latched faults: set wins over the shutdown-entry clear
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      faults_q <= '0;
    end else begin
      faults_q <= FAULT_EVT | (shutdown_enter ? '0 : faults_q);
    end
  end

  // ==========================================================
  // volume ramp and output stage
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      shutdown_q <= 1'b0;
      ramp_cnt_q <= '0;
      vol_level_q <= 8'h00;
      stage_q <= 1'b0;
      fault_n_q <= 1'b1;
    end else begin
      shutdown_q <= shutdown_d;
      ramp_cnt_q <= ramp_tick ? '0 : ramp_cnt_q + 16'd1;
      if (ramp_tick && vol_level_q > vol_target) begin
        vol_level_q <= vol_level_q - 8'd1;
      end else if (ramp_tick && vol_level_q < vol_target) begin
        vol_level_q <= vol_level_q + 8'd1;
      end
      // stage goes high impedance only once the ramp has reached silence
      if (stage_off_req && vol_level_q == 8'h00) begin
        stage_q <= 1'b0;
      end else if (!stage_off_req) begin
        stage_q <= 1'b1;
      end
      fault_n_q <= ~(fault_any | (CLOCK_ERR_IN & ~shutdown_d));
    end
  end

  // ==========================================================
  // digital clipper
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      dac_q <= '0;
      dac_valid_q <= 1'b0;
    end else begin
      dac_valid_q <= SAMPLE_VALID;
      if (SAMPLE_VALID) begin
        if (SAMPLE_IN > clip_pos) begin
          dac_q <= clip_pos;
        end else if (SAMPLE_IN < clip_neg) begin
          dac_q <= clip_neg;
        end else begin
          dac_q <= SAMPLE_IN;
        end
      end
    end
  end

  // ==========================================================
  // serial slave: bits sampled on SCL rise, SDA changed on SCL fall
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      scl_q <= 1'b1;
      scl_prev_q <= 1'b1;
      sda_q <= 1'b1;
      sda_prev_q <= 1'b1;
      state_q <= acr_pkg::S_IDLE;
      next_after_ack_q <= acr_pkg::S_IDLE;
      sda_oe_q <= 1'b0;
      cnt_q <= '0;
      shift_q <= '0;
      tx_q <= '0;
      ptr_q <= '0;
    end else begin
      scl_q <= SCL;
      scl_prev_q <= scl_q;
      sda_q <= SDA_I;
      sda_prev_q <= sda_q;
      if (start_seen) begin
        state_q <= acr_pkg::S_ADDR;
        cnt_q <= '0;
        sda_oe_q <= 1'b0;
      end else if (stop_seen) begin
        state_q <= acr_pkg::S_IDLE;
        sda_oe_q <= 1'b0;
      end else begin
        case (state_q)
          acr_pkg::S_ADDR, acr_pkg::S_REG, acr_pkg::S_WR: begin
            if (scl_rise) begin
              shift_q <= {shift_q[6:0], sda_q};
              cnt_q <= cnt_q + 4'd1;
            end else if (byte_done) begin
              sda_oe_q <= 1'b1;
              state_q <= acr_pkg::S_ACK;
              if (state_q == acr_pkg::S_ADDR) begin
                next_after_ack_q <= shift_q[0] ? acr_pkg::S_RD : acr_pkg::S_REG;
                if (!addr_hit) begin
                  sda_oe_q <= 1'b0;
                  state_q <= acr_pkg::S_IDLE;
                end
              end else if (state_q == acr_pkg::S_REG) begin
                ptr_q <= shift_q;
                next_after_ack_q <= acr_pkg::S_WR;
              end else begin
                ptr_q <= ptr_q + 8'd1;
              end
            end
          end
          acr_pkg::S_ACK: begin
            if (scl_fall) begin
              cnt_q <= '0;
              state_q <= next_after_ack_q;
              if (next_after_ack_q == acr_pkg::S_RD) begin
                tx_q <= {rd_data[6:0], 1'b0};
                sda_oe_q <= ~rd_data[7];
                ptr_q <= ptr_q + 8'd1;
              end else begin
                sda_oe_q <= 1'b0;
              end
            end
          end
          acr_pkg::S_RD: begin
            if (scl_fall && cnt_q == 4'd7) begin
              sda_oe_q <= 1'b0;
              state_q <= acr_pkg::S_MACK;
            end else if (scl_fall) begin
              sda_oe_q <= ~tx_q[7];
              tx_q <= {tx_q[6:0], 1'b0};
              cnt_q <= cnt_q + 4'd1;
            end
          end
          acr_pkg::S_MACK: begin
            // a master acknowledge asks for the next byte, a nack ends the read
            if (scl_rise) begin
              state_q <= sda_q ? acr_pkg::S_IDLE : acr_pkg::S_ACK;
            end
          end
          default: begin
            state_q <= acr_pkg::S_IDLE;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // outputs
  assign SDA_O = 1'b0;
  assign SDA_OE = sda_oe_q;
  assign SHUTDOWN_ACTIVE = shutdown_q;
  assign STAGE_ENABLE = stage_q;
  assign VOLUME_LEVEL = vol_level_q;
  assign FAULT_N = fault_n_q;
  assign DAC_SAMPLE = dac_q;
  assign DAC_VALID = dac_valid_q;
  assign CFG = '{dig_ctrl1: dig_ctrl1_q, dig_ctrl2: dig_ctrl2_q, analog: analog_q,
                 overcurrent_limit: fault_cfg_q[5:4]};
endmodule

// [common/acr_pkg.sv]
// Purpose: constants and types for the amplifier control register bank
// Assumes: byte-wide registers reached over a two-wire serial port
// Notes: one package, used by name only
package acr_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] OFS_PART_IDENT = 8'h00;
  localparam logic [7:0] OFS_POWER_CTRL = 8'h01;
  localparam logic [7:0] OFS_DIG_CTRL1 = 8'h02;
  localparam logic [7:0] OFS_DIG_CTRL2 = 8'h03;
  localparam logic [7:0] OFS_VOLUME = 8'h04;
  localparam logic [7:0] OFS_ANALOG = 8'h06;
  localparam logic [7:0] OFS_FAULT = 8'h08;
  localparam logic [7:0] OFS_CLIP_MID = 8'h10;
  localparam logic [7:0] OFS_CLIP_LOW = 8'h11;
  // ==========================================================
  // values after reset
  localparam logic [7:0] RST_POWER_CTRL = 8'hfd;
  localparam logic [7:0] RST_DIG_CTRL1 = 8'h04;
  localparam logic [7:0] RST_DIG_CTRL2 = 8'h80;
  localparam logic [7:0] RST_VOLUME = 8'hcf;
  localparam logic [7:0] RST_ANALOG = 8'h55;
  localparam logic [7:0] RST_FAULT_CFG = 8'h00;
  localparam logic [7:0] RST_CLIP_MID = 8'hff;
  localparam logic [7:0] RST_CLIP_LOW = 8'hfc;
  // ==========================================================
  // field positions
  localparam int BIT_SHUTDOWN_N = 0;
  localparam int BIT_SLEEP = 1;
  localparam int BIT_MUTE = 4;
  localparam int BIT_OVERHEAT = 0;
  localparam int BIT_DC_OFFSET = 1;
  localparam int BIT_OVERCURRENT = 2;
  localparam int BIT_CLOCK_ERR = 3;
  // ==========================================================
  // counts
  localparam int RAMP_STEP_CYCLES = 64;
  localparam int CLIP_W = 20;
  // ==========================================================
  // types
  typedef enum logic [6:0] {
    S_IDLE = 7'b000_0001,
    S_ADDR = 7'b000_0010,
    S_REG  = 7'b000_0100,
    S_WR   = 7'b000_1000,
    S_ACK  = 7'b001_0000,
    S_RD   = 7'b010_0000,
    S_MACK = 7'b100_0000
  } acr_state_t;
  typedef struct packed {
    logic [7:0] dig_ctrl1;
    logic [7:0] dig_ctrl2;
    logic [7:0] analog;
    logic [1:0] overcurrent_limit;
  } acr_cfg_t;
  typedef struct packed {
    logic overheat;
    logic overcurrent;
    logic dc_offset;
  } acr_faults_t;
endpackage

// [testbench/acr_amp_ctrl_chk.sv]
// Purpose: port checks of the amplifier control register bank
// Assumes: one clock domain, synchronous active-high reset
// Notes: bound to every acr_amp_ctrl instance
`timescale 1ns/1ns
module acr_amp_ctrl_chk (
  // clock, reset and serial port
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic SCL,
  input wire logic SDA_OE,
  // power and faults
  input wire logic SHUTDOWN_N_PIN,
  input wire acr_pkg::acr_faults_t FAULT_EVT,
  input wire logic SHUTDOWN_ACTIVE,
  input wire logic STAGE_ENABLE,
  input wire logic [7:0] VOLUME_LEVEL,
  input wire logic FAULT_N,
  // audio path
  input wire logic signed [acr_pkg::CLIP_W:0] SAMPLE_IN,
  input wire logic SAMPLE_VALID,
  input wire logic signed [acr_pkg::CLIP_W:0] DAC_SAMPLE,
  input wire logic DAC_VALID
);
  // last accepted sample, so a clipped output can be judged against its input
  logic signed [acr_pkg::CLIP_W:0] smp_q;
  always_ff @(posedge CORE_CLK) begin
    if (SAMPLE_VALID) begin
      smp_q <= SAMPLE_IN;
    end
  end
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  // ==========================================================
  // assertions
  pin_shutdown_a: assert property (!SHUTDOWN_N_PIN |=> SHUTDOWN_ACTIVE)
    else $error("shutdown pin ignored");
  shut_quiet_a: assert property (SHUTDOWN_ACTIVE && $past(SHUTDOWN_ACTIVE, 2)
    |-> VOLUME_LEVEL <= $past(VOLUME_LEVEL)) else $error("volume rose in shutdown");
  stage_quiet_a: assert property ($fell(STAGE_ENABLE) |-> VOLUME_LEVEL == 8'h00)
    else $error("stage stopped before volume reached zero");
  vol_step_a: assert property ($changed(VOLUME_LEVEL) && !$past(RST)
    |-> (VOLUME_LEVEL - $past(VOLUME_LEVEL)) inside {8'h01, 8'hff}) else $error("volume jumped");
  dac_strobe_a: assert property (SAMPLE_VALID |=> DAC_VALID)
    else $error("sample not passed on");
  clip_bound_a: assert property (DAC_VALID |-> ((smp_q >= 0) ?
    (DAC_SAMPLE >= 0 && DAC_SAMPLE <= smp_q) : (DAC_SAMPLE <= 0 && DAC_SAMPLE >= smp_q)))
    else $error("clipped sample grew");
  fault_flag_a: assert property (FAULT_EVT != '0 |-> ##[1:3] !FAULT_N)
    else $error("fault event not flagged");
  sda_phase_a: assert property ($changed(SDA_OE) && !$past(RST) |-> !SCL)
    else $error("data moved while serial clock high");
  cover property ($fell(STAGE_ENABLE));
  cover property (DAC_VALID && DAC_SAMPLE != smp_q);
  cover property ($fell(FAULT_N));
endmodule
bind acr_amp_ctrl acr_amp_ctrl_chk chk_u (.CORE_CLK, .RST, .SCL, .SDA_OE, .SHUTDOWN_N_PIN,
  .FAULT_EVT, .SHUTDOWN_ACTIVE, .STAGE_ENABLE, .VOLUME_LEVEL, .FAULT_N, .SAMPLE_IN,
  .SAMPLE_VALID, .DAC_SAMPLE, .DAC_VALID);

// [testbench/acr_i2c_host.sv]
// Purpose: two-wire host that configures the amplifier
// Assumes: each serial clock high phase lasts four core clocks, each low phase eight
// Notes: open drain; a released line floats high through the pull-up
`timescale 1ns/1ns
module acr_i2c_host (
  // clock and wire level
  input wire logic clk,
  input wire logic sda,
  // driven lines
  output logic scl,
  output logic sda_pull
);
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // ==========================================================
  // bit level: data moves only while scl is low, so no false start or stop
  task automatic hp();
    repeat (4) @(posedge clk);
  endtask
  task automatic put(input logic b);
    sda_pull <= !b;
    hp();
    scl <= 1'b1;
    hp();
    scl <= 1'b0;
    hp();
  endtask
  task automatic get(output logic b);
    sda_pull <= 1'b0;
    hp();
    scl <= 1'b1;
    hp();
    b = sda;
    scl <= 1'b0;
    hp();
  endtask
  // ==========================================================
  // byte level and framing
  task automatic wbyte(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) put(d[i]);
    get(ack);
    ack = !ack;
  endtask
  task automatic rbyte(input logic last, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) get(d[i]);
    put(last);
  endtask
  task automatic start();
    sda_pull <= 1'b1;
    hp();
    scl <= 1'b0;
    hp();
  endtask
  task automatic stop();
    sda_pull <= 1'b1;
    hp();
    scl <= 1'b1;
    hp();
    sda_pull <= 1'b0;
    hp();
  endtask
endmodule

// [testbench/tb_top.sv]
// Purpose: self-checking bench of the amplifier control register bank
// Assumes: ramp shortened to two cycles a step
// Notes: registers are reached only through the serial host model
`timescale 1ns/1ns
module tb_top;
  localparam logic [7:0] ID_CODE = 8'ha3; // arbitrary value
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic shdn_n = 1'b1;
  logic s_valid = 1'b0;
  logic signed [acr_pkg::CLIP_W:0] s_in = '0;
  acr_pkg::acr_faults_t evt = '0;
  logic signed [acr_pkg::CLIP_W:0] dac;
  logic scl, sda_pull, sda_oe, sda, dac_valid, shut, stage, fault_n;
  logic [7:0] vol;
  acr_pkg::acr_cfg_t cfg;
  int miscompares = 0;
  int check_count = 0;
  int cycles = 0;
  assign sda = !(sda_pull || sda_oe);
  always #10 core_clk = ~core_clk;
  acr_amp_ctrl #(.DEV_ADDR(7'h2c), .PART_IDENT_CODE(ID_CODE), .RAMP_CYCLES(2)) dut_u (
    .CORE_CLK(core_clk), .RST(rst), .SCL(scl), .SDA_I(sda), .SDA_O(), .SDA_OE(sda_oe),
    .SHUTDOWN_N_PIN(shdn_n), .CLOCK_ERR_IN(1'b0), .FAULT_EVT(evt), .SAMPLE_IN(s_in),
    .SAMPLE_VALID(s_valid), .DAC_SAMPLE(dac), .DAC_VALID(dac_valid), .SHUTDOWN_ACTIVE(shut),
    .STAGE_ENABLE(stage), .VOLUME_LEVEL(vol), .FAULT_N(fault_n), .CFG(cfg));
  acr_i2c_host host_u (.clk(core_clk), .sda(sda), .scl(scl), .sda_pull(sda_pull));
  // ==========================================================
  // shared tasks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
    logic a0, a1, a2;
    host_u.start();
    host_u.wbyte(8'h58, a0);
    host_u.wbyte(ofs, a1);
    host_u.wbyte(d, a2);
    host_u.stop();
    chk("write acks", 32'({a0, a1, a2}), 32'h7);
  endtask
  task automatic rchk(input string nm, input logic [7:0] ofs, input logic [7:0] exp);
    logic a0, a1, a2;
    logic [7:0] d;
    host_u.start();
    host_u.wbyte(8'h58, a0);
    host_u.wbyte(ofs, a1);
    host_u.stop();
    host_u.start();
    host_u.wbyte(8'h59, a2);
    host_u.rbyte(1'b1, d);
    host_u.stop();
    chk(nm, 32'({a0, a1, a2, d}), 32'({3'b111, exp}));
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset();
    logic [7:0] ofs [10] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h06, 8'h08, 8'h10, 8'h11, 8'h05};
    logic [7:0] exp [10] = '{ID_CODE, 8'hfd, 8'h04, 8'h80, 8'hcf, 8'h55, 8'h00, 8'hff, 8'hfc, 8'h00};
    chk("config after reset", 32'(cfg), 32'({8'h04, 8'h80, 8'h55, 2'b00}));
    for (int i = 0; i < 10; i++) rchk("reset value", ofs[i], exp[i]);
    wr(8'h00, 8'hff);
    rchk("ident after write", 8'h00, ID_CODE);
  endtask
  task automatic t_shutdown();
    chk("volume active", 32'({stage, vol}), 32'h1cf);
    wr(8'h01, 8'hfc);
    chk("shutdown by bit", 32'(shut), 32'h1);
    rchk("volume kept", 8'h04, 8'hcf);
    repeat (600) @(posedge core_clk);
    chk("stage off", 32'({stage, vol}), 32'h0);
    wr(8'h01, 8'hfd);
    chk("shutdown released", 32'(shut), 32'h0);
    shdn_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk("shutdown by pin", 32'(shut), 32'h1);
    shdn_n <= 1'b1;
    rchk("power kept", 8'h01, 8'hfd);
  endtask
  task automatic t_sleep();
    wr(8'h01, 8'hff);
    repeat (600) @(posedge core_clk);
    chk("sleep stage", 32'({shut, stage, vol}), 32'h0);
    wr(8'h01, 8'hfd);
    repeat (600) @(posedge core_clk);
    chk("wake stage", 32'({stage, vol}), 32'h1cf);
    wr(8'h03, 8'h90);
    repeat (600) @(posedge core_clk);
    chk("mute stage", 32'({stage, vol}), 32'h100);
    wr(8'h03, 8'h80);
    repeat (600) @(posedge core_clk);
    chk("unmute stage", 32'({stage, vol}), 32'h1cf);
  endtask
  task automatic t_fault();
    acr_pkg::acr_faults_t ev [3] = '{3'b100, 3'b010, 3'b001};
    logic [7:0] flag [3] = '{8'h01, 8'h04, 8'h02};
    for (int i = 0; i < 3; i++) begin
      evt <= ev[i];
      @(posedge core_clk);
      evt <= '0;
      repeat (3) @(posedge core_clk);
      chk("fault pin", 32'(fault_n), 32'h0);
      wr(8'h01, 8'hff);
      rchk("fault kept in sleep", 8'h08, flag[i]);
      wr(8'h01, 8'hfc);
      wr(8'h01, 8'hfd);
      rchk("fault cleared", 8'h08, 8'h00);
      rchk("volume after toggle", 8'h04, 8'hcf);
    end
  endtask
  task automatic t_clip();
    logic [7:0] pw [4] = '{8'h01, 8'h01, 8'h01, 8'h05};
    logic signed [acr_pkg::CLIP_W:0] si [4] = '{21'sh100, -21'sh100, 21'sh20, 21'sh1_0000};
    logic signed [acr_pkg::CLIP_W:0] so [4] = '{21'sh40, -21'sh40, 21'sh20, 21'sh4040};
    wr(8'h10, 8'h01);
    wr(8'h11, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(8'h01, pw[i]);
      s_in <= si[i];
      s_valid <= 1'b1;
      @(posedge core_clk);
      s_valid <= 1'b0;
      @(negedge core_clk);
      chk("clipped sample", 32'({dac_valid, dac}), 32'({1'b1, so[i]}));
      @(posedge core_clk);
    end
  endtask
  task automatic t_rerun();
    rst <= 1'b1;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    rchk("power after reset", 8'h01, 8'hfd);
    rchk("clip after reset", 8'h10, 8'hff);
  endtask
  // ==========================================================
  // timeout and main sequence
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 80000) begin
      miscompares++;
      wrap_up();
    end
  end
  initial begin
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    t_reset();
    t_shutdown();
    t_sleep();
    t_fault();
    t_clip();
    t_rerun();
    wrap_up();
  end
endmodule
